// file: rtl/spdif_tx_in.sv
`include "spdif_tx_in_defs.svh"
`default_nettype none

// --------------------------------------------------------------------
// Sample FIFO.
// --------------------------------------------------------------------
module sample_fifo #(
	parameter int WIDTH = 48,
	parameter int DEPTH = 16,
	parameter int AW = 4
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic en_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
	logic [AW:0] cnt_q, cnt_d;
	logic push, pop;

	// Handshakes are combinational; the count gives honest full and empty.
	always_comb begin
		in_ready_o = (cnt_q != (AW+1)'(DEPTH)) && en_i;
		out_valid_o = (cnt_q != '0);
		push = in_valid_i && in_ready_o;
		pop = out_valid_o && out_ready_i && en_i;
		wr_d = push ? AW'(wr_q + 1'b1) : wr_q;
		rd_d = pop ? AW'(rd_q + 1'b1) : rd_q;
		cnt_d = (AW+1)'(cnt_q + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0));
	end

	// Pointers and count.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else if (en_i) begin
			wr_q <= wr_d;
			rd_q <= rd_d;
			cnt_q <= cnt_d;
		end
	end

	// Storage has no reset; the head register samples mem_q[rd_d] every enabled cycle, written or not.
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_q[wr_q] <= in_data_i;
		end
	end

	// Head of queue, registered so the data output comes from flip-flops.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			out_data_o <= '0;
		end else if (en_i) begin
			out_data_o <= mem_q[rd_d];
		end
	end
endmodule

module spdif_tx_in
	import spdif_tx_in_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic en_i,
	input wire logic cfg_valid_i,
	input wire spdif_tx_in_pkg::fmt_t fmt_i,
	input wire spdif_tx_in_pkg::width_t width_i,
	input wire logic bclk_i,
	input wire logic lrclk_i,
	input wire logic sdata_i,
	output logic pair_valid_o,
	input wire logic pair_ready_i,
	output logic [`WORD_W-1:0] left_o,
	output logic [`WORD_W-1:0] right_o,
	output logic first_left_o,
	output logic overflow_o
);
	import spdif_tx_in_pkg::*;

	// ----------------------------------------------------------------
	// Configuration.
	// ----------------------------------------------------------------
	fmt_t fmt_q, fmt_d;
	width_t wid_q, wid_d;

	// Format is latched from the strobe; reset leaves I2S in force.
	always_comb begin
		fmt_d = fmt_q;
		wid_d = wid_q;
		if (cfg_valid_i && fmt_i != FMT_RESERVED) begin
			fmt_d = fmt_i;
			wid_d = width_i;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			fmt_q <= FMT_I2S_MODE;
			wid_q <= WIDTH_24;
		end else if (en_i) begin
			fmt_q <= fmt_d;
			wid_q <= wid_d;
		end
	end

	// ----------------------------------------------------------------
	// Pin synchronisers and bit-clock edge detection.
	// ----------------------------------------------------------------
	logic [2:0] s1_q, s2_q, s1_d, s2_d;
	logic bclk_prev_q, bclk_prev_d, rise;

	// First stage feeds only the second; edges are found on stage two.
	always_comb begin
		s1_d = {bclk_i, lrclk_i, sdata_i};
		s2_d = s1_q;
		bclk_prev_d = s2_q[2];
		rise = s2_q[2] && !bclk_prev_q;
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s1_q <= '0;
			s2_q <= '0;
			bclk_prev_q <= 1'b0;
		end else if (en_i) begin
			s1_q <= s1_d;
			s2_q <= s2_d;
			bclk_prev_q <= bclk_prev_d;
		end
	end

	// ----------------------------------------------------------------
	// Deserializer.
	// ----------------------------------------------------------------

	// Word length in bits for a width code.
	function automatic logic [`CNT_W-1:0] word_len(input width_t w);
		unique case (w)
			WIDTH_16: word_len = `LEN_16;
			WIDTH_18: word_len = `LEN_18;
			WIDTH_20: word_len = `LEN_20;
			WIDTH_24: word_len = `LEN_24;
		endcase
	endfunction

	// Bit position in the half-frame where the MSB lands.
	function automatic logic [`CNT_W-1:0] msb_slot(input fmt_t f, input width_t w);
		unique case (f)
			FMT_LEFT_JUST: msb_slot = `SLOT_LJ;
			FMT_I2S_MODE: msb_slot = `SLOT_I2S;
			default: msb_slot = `CNT_W'(`HALF_BITS - word_len(w));
		endcase
	endfunction

	logic lr_prev_q, lr_prev_d;
	logic [`CNT_W-1:0] pos_q, pos_d;
	logic [`WORD_W-1:0] sh_q, sh_d, left_q, left_d;
	logic done_q, done_d;
	logic push_valid, push_ready, is_left, frame_edge, cur_left;
	logic [`CNT_W-1:0] start, len, slot;
	logic [`SAMPLE_W-1:0] push_data;
	logic ovf_q, ovf_d;

	// Channel polarity: I2S is low-for-left, the other two high-for-left.
	// A word is finished when its LSB is taken; right word completes a pair.
	always_comb begin
		lr_prev_d = lr_prev_q;
		pos_d = pos_q;
		sh_d = sh_q;
		left_d = left_q;
		done_d = done_q;
		push_valid = 1'b0;
		push_data = {left_q, sh_q};
		ovf_d = ovf_q;
		start = msb_slot(fmt_q, wid_q);
		len = word_len(wid_q);
		frame_edge = s2_q[1] != lr_prev_q;
		slot = frame_edge ? `SLOT_FIRST : pos_q; // Slot index of the current bit in its half-frame.
		cur_left = (fmt_q == FMT_I2S_MODE) ? !s2_q[1] : s2_q[1];
		is_left = cur_left;
		if (rise) begin
			lr_prev_d = s2_q[1];
			pos_d = frame_edge ? `SLOT_NEXT : `CNT_W'(pos_q + 1'b1);
			// Bits are placed from MSB downward; shorter words sit left-aligned.
			if (slot >= start && slot < `CNT_W'(start + len)) begin
				sh_d = {sh_q[`WORD_W-2:0], s2_q[0]};
				if (slot == `CNT_W'(start + len - 1'b1)) begin
					sh_d = `WORD_W'({sh_q[`WORD_W-2:0], s2_q[0]} << (`WORD_W - len));
					if (is_left) begin
						left_d = sh_d;
						done_d = 1'b1;
					end else if (done_q) begin
						push_valid = 1'b1;
						push_data = {left_q, sh_d};
						done_d = 1'b0;
					end
				end
			end else if (frame_edge && slot < start) begin
				sh_d = '0;
			end
		end
		if (push_valid && !push_ready) begin
			ovf_d = 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			lr_prev_q <= 1'b0;
			pos_q <= '0;
			sh_q <= '0;
			left_q <= '0;
			done_q <= 1'b0;
			ovf_q <= 1'b0;
		end else if (en_i) begin
			lr_prev_q <= lr_prev_d;
			pos_q <= pos_d;
			sh_q <= sh_d;
			left_q <= left_d;
			done_q <= done_d;
			ovf_q <= ovf_d;
		end
	end

	// ----------------------------------------------------------------
	// Output buffering toward the encoder.
	// ----------------------------------------------------------------
	// The serial source cannot be stalled, so a full FIFO drops the pair
	// and raises the sticky overflow flag instead.
	logic [`SAMPLE_W-1:0] pop_data;

	sample_fifo #(
		.WIDTH(`SAMPLE_W),
		.DEPTH(`FIFO_DEPTH),
		.AW(`FIFO_AW)
	) u_fifo (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.en_i(en_i),
		.in_valid_i(push_valid),
		.in_ready_o(push_ready),
		.in_data_i(push_data),
		.out_valid_o(pair_valid_o),
		.out_ready_i(pair_ready_i),
		.out_data_o(pop_data)
	);

	// Both words of a pair leave together on left_o and right_o; first_left_o is held high.
	always_comb begin
		left_o = pop_data[`SAMPLE_W-1:`WORD_W];
		right_o = pop_data[`WORD_W-1:0];
		first_left_o = 1'b1;
		overflow_o = ovf_q;
	end
endmodule
`default_nettype wire

// file: rtl/spdif_tx_in_defs.svh
`ifndef SPDIF_TX_IN_DEFS_SVH
`define SPDIF_TX_IN_DEFS_SVH
`define WORD_W 24
`define HALF_BITS 6'd32
`define CNT_W 6
`define SAMPLE_W 48
`define FIFO_DEPTH 16
`define FIFO_AW 4
`define FMT_LJ 2'h0
`define FMT_I2S 2'h1
`define FMT_RJ 2'h2
`define WID_16 2'h0
`define WID_18 2'h1
`define WID_20 2'h2
`define WID_24 2'h3
`define LEN_16 6'd16
`define LEN_18 6'd18
`define LEN_20 6'd20
`define LEN_24 6'd24
`define SLOT_LJ 6'd0
`define SLOT_I2S 6'd1
`define SLOT_FIRST 6'd0
`define SLOT_NEXT 6'd1
`endif

// file: rtl/spdif_tx_in_pkg.sv
`default_nettype none
package spdif_tx_in_pkg;
	typedef enum logic [1:0] {
		FMT_LEFT_JUST,
		FMT_I2S_MODE,
		FMT_RIGHT_JUST,
		FMT_RESERVED
	} fmt_t;
	typedef enum logic [1:0] {
		WIDTH_16,
		WIDTH_18,
		WIDTH_20,
		WIDTH_24
	} width_t;
endpackage
`default_nettype wire

// file: verification/audio_src_model.sv
`default_nettype none
// ----------------------------------------
// Serial audio source on the far side.
// ----------------------------------------
module audio_src_model (
	output var logic bclk_o,
	output var logic lrclk_o,
	output var logic sdata_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// The bit clock rests low between frames, so idle time sends nothing.
	initial begin
		bclk_o = 1'b0;
		lrclk_o = 1'b1;
		sdata_o = 1'b0;
	end
	// One frame of 64 bit clocks; a lead-in slot first, when lrclk is not already at the right-channel level, makes the left edge visible.
	task automatic send(input int fmt, input int len, input logic [23:0] l, input logic [23:0] r);
		int msb;
		int b;
		logic rl;
		rl = (fmt == 1);
		msb = (fmt == 0) ? 0 : (fmt == 1) ? 1 : 32 - len;
		#3;
		for (int s = (lrclk_o == rl) ? 0 : -1; s < 64; s++) begin
			lrclk_o = (s < 0 || s >= 32) ? rl : !rl;
			b = (s & 31) - msb;
			sdata_o = (b >= 0 && b < len) ? (lrclk_o == rl ? r[len-1-b] : l[len-1-b]) : ~sdata_o;
			#80 bclk_o = 1'b1;
			#80 bclk_o = 1'b0;
		end
		sdata_o = ~sdata_o;
	endtask
endmodule
`default_nettype wire

// file: verification/spdif_tx_in_properties.sv
`include "spdif_tx_in_defs.svh"
`default_nettype none
// ----------------------------------------
// Port checks of the serial input stage.
// ----------------------------------------
module spdif_tx_in_properties (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic en_i,
	input wire logic pair_ready_i,
	input wire logic pair_valid_o,
	input wire logic [`WORD_W-1:0] left_o,
	input wire logic [`WORD_W-1:0] right_o,
	input wire logic first_left_o,
	input wire logic overflow_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// A pair offered but not taken; held three cycles its head data has settled.
	sequence s_held;
		pair_valid_o && !pair_ready_i;
	endsequence
	a_flag_high: assert property (first_left_o)
		else $error("channel flag low");
	a_valid_stays: assert property (s_held |=> pair_valid_o)
		else $error("pair lost before pop");
	a_data_stays: assert property (s_held [*3] |=> $stable({left_o, right_o}))
		else $error("held pair changed");
	a_ovf_sticky: assert property (overflow_o |=> overflow_o)
		else $error("overflow cleared");
	a_ovf_cause: assert property ($rose(overflow_o) |-> $past(pair_valid_o))
		else $error("overflow with empty buffer");
	a_pop_only: assert property ($fell(pair_valid_o) |-> $past(pair_ready_i && en_i))
		else $error("pair gone without pop");
	a_freeze_flags: assert property (!en_i |=> $stable(pair_valid_o) && $stable(overflow_o))
		else $error("flags moved while disabled");
	a_freeze_data: assert property (!en_i |=> $stable({left_o, right_o}))
		else $error("data moved while disabled");
endmodule
bind spdif_tx_in spdif_tx_in_properties u_props (.clk_i, .rst_n_i, .en_i, .pair_ready_i, .pair_valid_o,
	.left_o, .right_o, .first_left_o, .overflow_o);
`default_nettype wire

// file: verification/testbench.sv
`default_nettype none
// ----------------------------------------
// Self-checking bench of the input stage.
// ----------------------------------------
module testbench import spdif_tx_in_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic en_i = 1'b1;
	logic cfg_valid_i = 1'b0;
	fmt_t fmt_i = FMT_I2S_MODE;
	width_t width_i = WIDTH_24;
	logic pair_ready_i = 1'b0;
	logic bclk, lrclk, sdata, pair_valid_o, first_left_o, overflow_o;
	logic [23:0] left_o, right_o;
	logic [31:0] seed = 32'h0000002A;
	logic [47:0] exp_q[$];
	int mismatches = 0;
	int n_tests = 0;
	always #5 clk_i = ~clk_i;
	audio_src_model u_audio_src_model (.bclk_o(bclk), .lrclk_o(lrclk), .sdata_o(sdata));
	spdif_tx_in u_spdif_tx_in (.clk_i, .rst_n_i, .en_i, .cfg_valid_i, .fmt_i, .width_i, .bclk_i(bclk),
		.lrclk_i(lrclk), .sdata_i(sdata), .pair_valid_o, .pair_ready_i, .left_o, .right_o, .first_left_o, .overflow_o);
	// Random words and their MSB-aligned images.
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [47:0] aligned(logic [23:0] l, logic [23:0] r, int len);
		return {l << (24 - len), r << (24 - len)};
	endfunction
	task automatic check(input logic [47:0] seen, input logic [47:0] want);
		n_tests++;
		if (seen !== want) begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, seen, want);
		end
	endtask
	task automatic cfg(input fmt_t f, input width_t w);
		fmt_i = f;
		width_i = w;
		cfg_valid_i = 1'b1;
		@(negedge clk_i);
		cfg_valid_i = 1'b0;
	endtask
	// The first frame carries a silent right channel as a corner case.
	task automatic frame(input int f, input int len, input bit keep);
		logic [23:0] l;
		logic [23:0] r;
		l = 24'(xs()) >> (24 - len);
		r = (n_tests == 0) ? 24'h000000 : 24'(xs()) >> (24 - len);
		u_audio_src_model.send(f, len, l, r);
		if (keep) exp_q.push_back(aligned(l, r, len));
	endtask
	// Data is trusted only two cycles after the flag, since the head is registered.
	task automatic take();
		for (int i = 0; i < 3000 && pair_valid_o !== 1'b1; i++) @(negedge clk_i);
		// A pair that never shows up is a failure in its own right.
		if (pair_valid_o !== 1'b1) mismatches++;
		repeat (2) @(negedge clk_i);
		check({left_o, right_o}, exp_q.pop_front());
		check({47'h0, first_left_o}, 48'h1);
		pair_ready_i = 1'b1;
		@(negedge clk_i);
		pair_ready_i = 1'b0;
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// A hang is cut short well past the expected 308 us of traffic.
	initial begin
		#600us;
		mismatches++;
		tally_and_finish();
	end
	// Default framing, every format and width, a reserved format, then overflow.
	initial begin
		repeat (12) @(negedge clk_i);
		rst_n_i = 1'b1;
		@(negedge clk_i);
		frame(1, 24, 1);
		take();
		for (int f = 0; f < 3; f++) begin
			for (int w = 0; w < 4; w++) begin
				cfg(fmt_t'(f), width_t'(w));
				frame(f, 16 + 2 * w + 2 * (w / 3), 1);
				take();
			end
		end
		cfg(FMT_RESERVED, WIDTH_24);
		for (int i = 0; i < 17; i++) frame(2, 24, i < 16);
		check({47'h0, overflow_o}, 48'h1);
		en_i = 1'b0;
		pair_ready_i = 1'b1;
		repeat (4) @(negedge clk_i);
		check({47'h0, pair_valid_o}, 48'h1);
		en_i = 1'b1;
		pair_ready_i = 1'b0;
		repeat (16) take();
		@(negedge clk_i);
		check({47'h0, pair_valid_o}, 48'h0);
		tally_and_finish();
	end
endmodule
`default_nettype wire
